// file: hw/oam_endpoint_engine.sv
// per-endpoint continuity and test pdu receive/transmit processing
// assumes all *_VLD inputs are one-cycle pulses with their data valid
// alongside, and timer expiry inputs are one-cycle pulses

module oam_endpoint_engine (
  input  wire logic                         SYS_CLK,
  input  wire logic                         SYS_RST,
  input  wire logic                         RX_CONT_VLD,
  input  wire logic                         RX_CONT_INVLD,
  input  wire logic                         RX_CONT_IS_LOSS,
  input  wire logic [oam_pkg::SEQ_W-1:0]    RX_CONT_SEQ,
  input  wire logic                         RX_CONT_RDI,
  input  wire logic [oam_pkg::PORT_W-1:0]   RX_SRC_PORT,
  input  wire logic                         RX_SRC_IS_LAG,
  input  wire logic [oam_pkg::PORT_W-1:0]   RX_LAG_MEMBER,
  input  wire logic [oam_pkg::TLV_W-1:0]    RX_TLV0_TYPE,
  input  wire logic [oam_pkg::TLV_W-1:0]    RX_TLV0_VAL,
  input  wire logic [oam_pkg::TLV_W-1:0]    RX_TLV1_TYPE,
  input  wire logic [oam_pkg::TLV_W-1:0]    RX_TLV1_VAL,
  input  wire logic [oam_pkg::NTIMER-1:0]   TIMER_EXPIRE,
  input  wire logic [oam_pkg::TSEL_W-1:0]   LOSS_TIMER_SELECT,
  input  wire logic [oam_pkg::TSEL_W-1:0]   LOSS_INSERT_TIMER_SELECT,
  input  wire logic                         LOSS_INSERT_TIMER_ENABLE,
  input  wire logic                         INSERT_LOSS_SET,
  input  wire logic                         TX_CONT_VLD,
  input  wire logic                         RX_SEQ_CHECK_ENABLE,
  input  wire logic [oam_pkg::RUN_W-1:0]    PORT_STABLE_THRESHOLD,
  input  wire logic [oam_pkg::FLAG_W-1:0]   FLAG_CLEAR,
  input  wire logic [oam_pkg::FLAG_W-1:0]   IRQ_ENABLE,
  input  wire logic                         EXTRACT_NEXT_CONT_SET,
  input  wire logic                         EXTRACT_NEXT_TEST_SET,
  input  wire logic                         COPY_ALL_CONT_TO_CPU,
  input  wire logic                         COPY_ALL_CONT_LOSS_TO_CPU,
  input  wire logic                         COPY_ALL_TEST_TO_CPU,
  input  wire logic                         EXTRACT_END_TLV_ENABLE,
  input  wire logic                         TEST_PDU_HW_ENABLE,
  input  wire logic                         TEST_PDU_OAM_COUNT_ENABLE,
  input  wire logic                         TEST_PDU_LOSS_COUNT_ENABLE,
  input  wire logic                         TEST_PDU_SEQ_WRITE_ENABLE,
  input  wire logic                         RX_TEST_VLD,
  input  wire logic [oam_pkg::SEQ_W-1:0]    RX_TEST_SEQ,
  input  wire logic                         TX_TEST_VLD,
  output logic      [oam_pkg::FLAG_W-1:0]   FLAGS,
  output logic                              IRQ,
  output logic      [oam_pkg::SEQ_W-1:0]    STORED_RX_SEQ_VALUE,
  output logic      [oam_pkg::CNT_W-1:0]    RX_OUT_OF_SEQ_COUNTER,
  output logic      [oam_pkg::CNT_W-1:0]    CONT_VALID_RX_COUNTER,
  output logic      [oam_pkg::CNT_W-1:0]    CONT_INVALID_RX_COUNTER,
  output logic                              LAST_REMOTE_DEFECT_VALUE,
  output logic      [oam_pkg::MISS_W-1:0]   CONTINUITY_MISS_COUNTER,
  output logic                              LOSS_OF_CONTINUITY_DEFECT,
  output logic      [oam_pkg::PORT_W-1:0]   LAST_SOURCE_PORT,
  output logic      [oam_pkg::RUN_W-1:0]    SAME_PORT_RUN_COUNTER,
  output logic      [oam_pkg::TLV_W-1:0]    SAMPLED_PORT_STATE,
  output logic      [oam_pkg::TLV_W-1:0]    SAMPLED_IF_STATE,
  output logic                              INSERT_LOSS_NEXT_REQUEST,
  output logic                              TX_INSERT_LOSS,
  output logic                              TX_TEST_SEQ_WRITE,
  output logic      [oam_pkg::SEQ_W-1:0]    TX_TEST_SEQ_OUT,
  output logic      [oam_pkg::SEQ_W-1:0]    TX_TRANSACTION_ID_STORE,
  output logic      [oam_pkg::SEQ_W-1:0]    RX_TRANSACTION_ID_STORE,
  output logic      [oam_pkg::CNT_W-1:0]    TEST_VALID_RX_COUNTER,
  output logic      [oam_pkg::CNT_W-1:0]    TRANSACTION_ID_ERROR_COUNTER,
  output logic                              EXTRACT_NEXT_CONT_PDU,
  output logic                              EXTRACT_NEXT_TEST_PDU,
  output logic                              CPU_COPY,
  output logic                              TEST_OAM_COUNT_INC,
  output logic                              TEST_LOSS_COUNT_INC
);
  function automatic oam_pkg::tlv_kind_e tlv_kind(
    input logic [oam_pkg::TLV_W-1:0] t);
    if (t == oam_pkg::TLV_END) begin
      return oam_pkg::TK_END;
    end else if (t == oam_pkg::TLV_PORT) begin
      return oam_pkg::TK_PORT;
    end else if (t == oam_pkg::TLV_IF) begin
      return oam_pkg::TK_IF;
    end
    return oam_pkg::TK_OTHER;
  endfunction

  oam_pkg::tlv_kind_e             kind0;
  oam_pkg::tlv_kind_e             kind1;
  logic                           port_hit;
  logic                           if_hit;
  logic                           end_tlv_bad;
  logic [oam_pkg::TLV_W-1:0]      port_val;
  logic [oam_pkg::TLV_W-1:0]      if_val;
  logic [oam_pkg::PORT_W-1:0]     arr_port;
  logic [oam_pkg::RUN_W-1:0]      run_nxt;
  logic [oam_pkg::FLAG_W-1:0]     flag_set;
  logic                           cont_mismatch;
  logic                           test_mismatch;
  logic                           loc_chg;
  logic                           loc_tick;
  logic                           ins_tick;
  logic                           test_hw_vld;
  logic                           copy_nxt;

  assign kind0 = tlv_kind(RX_TLV0_TYPE);
  assign kind1 = tlv_kind(RX_TLV1_TYPE);
  assign loc_tick = TIMER_EXPIRE[LOSS_TIMER_SELECT];
  assign ins_tick = LOSS_INSERT_TIMER_ENABLE &&
                    TIMER_EXPIRE[LOSS_INSERT_TIMER_SELECT];
  assign test_hw_vld = RX_TEST_VLD && TEST_PDU_HW_ENABLE;
  assign arr_port = RX_SRC_IS_LAG ? RX_LAG_MEMBER : RX_SRC_PORT;

  // leading status tlvs in either order; anything else first stops parse
  always_comb begin
    port_hit    = 1'b0;
    if_hit      = 1'b0;
    end_tlv_bad = 1'b0;
    port_val    = RX_TLV0_VAL;
    if_val      = RX_TLV0_VAL;
    case (kind0)
      oam_pkg::TK_PORT: port_hit = 1'b1;
      oam_pkg::TK_IF:   if_hit   = 1'b1;
      oam_pkg::TK_END:  end_tlv_bad = 1'b0;
      default:          end_tlv_bad = 1'b1;
    endcase
    if (kind0 == oam_pkg::TK_PORT || kind0 == oam_pkg::TK_IF) begin
      case (kind1)
        oam_pkg::TK_PORT: begin
          if (kind0 == oam_pkg::TK_IF) begin
            port_hit = 1'b1;
            port_val = RX_TLV1_VAL;
          end else begin
            end_tlv_bad = 1'b1;
          end
        end
        oam_pkg::TK_IF: begin
          if (kind0 == oam_pkg::TK_PORT) begin
            if_hit = 1'b1;
            if_val = RX_TLV1_VAL;
          end else begin
            end_tlv_bad = 1'b1;
          end
        end
        oam_pkg::TK_END: end_tlv_bad = 1'b0;
        default:         end_tlv_bad = 1'b1;
      endcase
    end
  end

  always_comb begin
    if (arr_port != LAST_SOURCE_PORT) begin
      run_nxt = '0;
    end else if (SAME_PORT_RUN_COUNTER != oam_pkg::RUN_MAX) begin
      run_nxt = SAME_PORT_RUN_COUNTER + 8'h01;
    end else begin
      run_nxt = SAME_PORT_RUN_COUNTER;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[oam_pkg::F_CONT_SEEN] = RX_CONT_VLD;
    flag_set[oam_pkg::F_LOSS_SEEN] = RX_CONT_VLD && RX_CONT_IS_LOSS;
    flag_set[oam_pkg::F_SEQ_ERR]   = cont_mismatch;
    flag_set[oam_pkg::F_RDI_CHG]   = RX_CONT_VLD &&
      (RX_CONT_RDI != LAST_REMOTE_DEFECT_VALUE);
    flag_set[oam_pkg::F_LOC_CHG]   = loc_chg;
    flag_set[oam_pkg::F_PORT_STBL] = RX_CONT_VLD &&
      run_nxt == PORT_STABLE_THRESHOLD &&
      run_nxt != SAME_PORT_RUN_COUNTER;
    flag_set[oam_pkg::F_PSTATE_CHG] = RX_CONT_VLD && port_hit &&
      port_val != SAMPLED_PORT_STATE;
    flag_set[oam_pkg::F_ISTATE_CHG] = RX_CONT_VLD && if_hit &&
      if_val != SAMPLED_IF_STATE;
    flag_set[oam_pkg::F_TEST_SEEN] = RX_TEST_VLD;
    flag_set[oam_pkg::F_TID_ERR]   = test_mismatch;
    flag_set[oam_pkg::F_END_TLV]   = RX_CONT_VLD && end_tlv_bad;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FLAGS <= '0;
    end else begin
      FLAGS <= (FLAGS & ~FLAG_CLEAR) | flag_set;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((FLAGS & ~FLAG_CLEAR) | flag_set) & IRQ_ENABLE &
               oam_pkg::IRQ_MASK);
    end
  end

  seq_tracker u_cont_seq (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .vld       (RX_CONT_VLD),
    .chk_en    (RX_SEQ_CHECK_ENABLE),
    .upd_en    (1'b1),
    .seq_in    (RX_CONT_SEQ),
    .mismatch  (cont_mismatch),
    .stored_r  (STORED_RX_SEQ_VALUE),
    .err_cnt_r (RX_OUT_OF_SEQ_COUNTER),
    .vld_cnt_r (CONT_VALID_RX_COUNTER)
  );

  seq_tracker u_test_seq (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .vld       (RX_TEST_VLD),
    .chk_en    (1'b1),
    .upd_en    (TEST_PDU_HW_ENABLE),
    .seq_in    (RX_TEST_SEQ),
    .mismatch  (test_mismatch),
    .stored_r  (RX_TRANSACTION_ID_STORE),
    .err_cnt_r (TRANSACTION_ID_ERROR_COUNTER),
    .vld_cnt_r (TEST_VALID_RX_COUNTER)
  );

  loc_monitor u_loc (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .tick     (loc_tick),
    .clr      (RX_CONT_VLD),
    .miss_r   (CONTINUITY_MISS_COUNTER),
    .defect_r (LOSS_OF_CONTINUITY_DEFECT),
    .chg_r    (loc_chg)
  );

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CONT_INVALID_RX_COUNTER <= '0;
    end else if (RX_CONT_INVLD) begin
      CONT_INVALID_RX_COUNTER <= CONT_INVALID_RX_COUNTER +
                                 oam_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LAST_REMOTE_DEFECT_VALUE <= 1'b0;
    end else if (RX_CONT_VLD) begin
      LAST_REMOTE_DEFECT_VALUE <= RX_CONT_RDI;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LAST_SOURCE_PORT      <= '0;
      SAME_PORT_RUN_COUNTER <= '0;
    end else if (RX_CONT_VLD) begin
      LAST_SOURCE_PORT      <= arr_port;
      SAME_PORT_RUN_COUNTER <= run_nxt;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SAMPLED_PORT_STATE <= '0;
      SAMPLED_IF_STATE   <= '0;
    end else if (RX_CONT_VLD) begin
      if (port_hit) begin
        SAMPLED_PORT_STATE <= port_val;
      end
      if (if_hit) begin
        SAMPLED_IF_STATE <= if_val;
      end
    end
  end

  // loss insertion request; a new set in the using cycle survives
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INSERT_LOSS_NEXT_REQUEST <= 1'b0;
      TX_INSERT_LOSS           <= 1'b0;
    end else begin
      TX_INSERT_LOSS <= TX_CONT_VLD && INSERT_LOSS_NEXT_REQUEST;
      if (INSERT_LOSS_SET || ins_tick) begin
        INSERT_LOSS_NEXT_REQUEST <= 1'b1;
      end else if (TX_CONT_VLD) begin
        INSERT_LOSS_NEXT_REQUEST <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_TRANSACTION_ID_STORE <= '0;
      TX_TEST_SEQ_OUT         <= '0;
      TX_TEST_SEQ_WRITE       <= 1'b0;
    end else begin
      TX_TEST_SEQ_WRITE <= TX_TEST_VLD && TEST_PDU_HW_ENABLE &&
                           TEST_PDU_SEQ_WRITE_ENABLE;
      if (TX_TEST_VLD && TEST_PDU_HW_ENABLE) begin
        TX_TEST_SEQ_OUT         <= TX_TRANSACTION_ID_STORE;
        TX_TRANSACTION_ID_STORE <= TX_TRANSACTION_ID_STORE +
                                   oam_pkg::SEQ_STEP;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TEST_OAM_COUNT_INC  <= 1'b0;
      TEST_LOSS_COUNT_INC <= 1'b0;
    end else begin
      TEST_OAM_COUNT_INC  <= (RX_TEST_VLD || TX_TEST_VLD) &&
                             TEST_PDU_OAM_COUNT_ENABLE;
      TEST_LOSS_COUNT_INC <= (RX_TEST_VLD || TX_TEST_VLD) &&
                             TEST_PDU_LOSS_COUNT_ENABLE;
    end
  end

  // one-shot extraction arms, used by the next matching pdu
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXTRACT_NEXT_CONT_PDU <= 1'b0;
      EXTRACT_NEXT_TEST_PDU <= 1'b0;
    end else begin
      if (EXTRACT_NEXT_CONT_SET) begin
        EXTRACT_NEXT_CONT_PDU <= 1'b1;
      end else if (RX_CONT_VLD) begin
        EXTRACT_NEXT_CONT_PDU <= 1'b0;
      end
      if (EXTRACT_NEXT_TEST_SET) begin
        EXTRACT_NEXT_TEST_PDU <= 1'b1;
      end else if (RX_TEST_VLD) begin
        EXTRACT_NEXT_TEST_PDU <= 1'b0;
      end
    end
  end

  always_comb begin
    copy_nxt = 1'b0;
    if (RX_CONT_VLD) begin
      copy_nxt = EXTRACT_NEXT_CONT_PDU ||
        (RX_CONT_IS_LOSS ? COPY_ALL_CONT_LOSS_TO_CPU
                         : COPY_ALL_CONT_TO_CPU) ||
        (end_tlv_bad && EXTRACT_END_TLV_ENABLE);
    end
    if (RX_TEST_VLD) begin
      copy_nxt = copy_nxt || EXTRACT_NEXT_TEST_PDU ||
                 COPY_ALL_TEST_TO_CPU;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CPU_COPY <= 1'b0;
    end else begin
      CPU_COPY <= copy_nxt;
    end
  end

  chk_seq_err_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    cont_mismatch |=> FLAGS[oam_pkg::F_SEQ_ERR])
    else $error("sequence error flag not set");
  chk_seq_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    RX_CONT_VLD |=> STORED_RX_SEQ_VALUE == $past(RX_CONT_SEQ))
    else $error("receive sequence not stored");
  chk_miss_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    RX_CONT_VLD |=> CONTINUITY_MISS_COUNTER == 3'h0)
    else $error("miss counter not cleared");
  chk_loc_defect: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    LOSS_OF_CONTINUITY_DEFECT |->
      CONTINUITY_MISS_COUNTER == oam_pkg::MISS_LIMIT)
    else $error("defect without full miss count");
  chk_loc_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $changed(LOSS_OF_CONTINUITY_DEFECT) |=>
      FLAGS[oam_pkg::F_LOC_CHG])
    else $error("defect change not flagged");
  chk_rdi_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    RX_CONT_VLD && RX_CONT_RDI != LAST_REMOTE_DEFECT_VALUE |=>
      FLAGS[oam_pkg::F_RDI_CHG] && LAST_REMOTE_DEFECT_VALUE ==
      $past(RX_CONT_RDI))
    else $error("rdi change missed");
  chk_insert_clear: assert property (@(posedge SYS_CLK)
    disable iff (SYS_RST)
    TX_CONT_VLD && INSERT_LOSS_NEXT_REQUEST && !INSERT_LOSS_SET &&
      !ins_tick |=> TX_INSERT_LOSS && !INSERT_LOSS_NEXT_REQUEST)
    else $error("loss insertion not consumed");
  chk_tx_id_step: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    TX_TEST_VLD && TEST_PDU_HW_ENABLE |=> TX_TRANSACTION_ID_STORE ==
      $past(TX_TRANSACTION_ID_STORE) + oam_pkg::SEQ_STEP)
    else $error("transmit id did not step");
  chk_irq_level: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    |(FLAGS & IRQ_ENABLE & oam_pkg::IRQ_MASK) && FLAG_CLEAR == '0 |=>
      IRQ)
    else $error("interrupt missing");
  cov_loc_raise: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(LOSS_OF_CONTINUITY_DEFECT));
  cov_port_stable: cover property (@(posedge SYS_CLK)
    disable iff (SYS_RST) $rose(FLAGS[oam_pkg::F_PORT_STBL]));
  cov_test_err: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
    test_mismatch);
endmodule

// file: hw/oam_pkg.sv
// constants for the oam continuity and test pdu unit
// assumes one 250 MHz clock and one-cycle event pulses from the datapath
package oam_pkg;
  localparam int SEQ_W   = 32;
  localparam int CNT_W   = 32;
  localparam int PORT_W  = 6;
  localparam int RUN_W   = 8;
  localparam int TLV_W   = 8;
  localparam int NTIMER  = 8;
  localparam int TSEL_W  = 3;
  localparam int MISS_W  = 3;
  localparam logic [MISS_W-1:0] MISS_LIMIT = 3'h7;
  localparam logic [SEQ_W-1:0]  SEQ_STEP   = 32'h00000001;
  localparam logic [CNT_W-1:0]  CNT_STEP   = 32'h00000001;
  localparam logic [RUN_W-1:0]  RUN_MAX    = 8'hFF;
  // flag vector positions
  localparam int FLAG_W       = 11;
  localparam int F_CONT_SEEN  = 0;
  localparam int F_LOSS_SEEN  = 1;
  localparam int F_SEQ_ERR    = 2;
  localparam int F_RDI_CHG    = 3;
  localparam int F_LOC_CHG    = 4;
  localparam int F_PORT_STBL  = 5;
  localparam int F_PSTATE_CHG = 6;
  localparam int F_ISTATE_CHG = 7;
  localparam int F_TEST_SEEN  = 8;
  localparam int F_TID_ERR    = 9;
  localparam int F_END_TLV    = 10;
  localparam logic [FLAG_W-1:0] IRQ_MASK = 11'h0F8;
  // tlv type codes
  localparam logic [TLV_W-1:0] TLV_END  = 8'h00;
  localparam logic [TLV_W-1:0] TLV_PORT = 8'h02;
  localparam logic [TLV_W-1:0] TLV_IF   = 8'h04;
  typedef enum logic [1:0] {TK_END, TK_PORT, TK_IF, TK_OTHER} tlv_kind_e;
endpackage

// file: hw/seq_tracker.sv
// sequence store, expected-value check and pdu counters
// assumes vld is a one-cycle pulse per valid pdu
module seq_tracker (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       vld,
  input  wire logic                       chk_en,
  input  wire logic                       upd_en,
  input  wire logic [oam_pkg::SEQ_W-1:0]  seq_in,
  output wire logic                       mismatch,
  output logic      [oam_pkg::SEQ_W-1:0]  stored_r,
  output logic      [oam_pkg::CNT_W-1:0]  err_cnt_r,
  output logic      [oam_pkg::CNT_W-1:0]  vld_cnt_r
);
  assign mismatch = vld && upd_en && chk_en &&
                    (seq_in != stored_r + oam_pkg::SEQ_STEP);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stored_r <= '0;
    end else if (vld && upd_en) begin
      stored_r <= seq_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_cnt_r <= '0;
    end else if (mismatch) begin
      err_cnt_r <= err_cnt_r + oam_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vld_cnt_r <= '0;
    end else if (vld) begin
      vld_cnt_r <= vld_cnt_r + oam_pkg::CNT_STEP;
    end
  end
endmodule

// file: hw/loc_monitor.sv
// 3-bit miss counter with loss-of-continuity defect and change pulse
// assumes tick is one pulse per expiry of the assigned timer
module loc_monitor (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        tick,
  input  wire logic                        clr,
  output logic      [oam_pkg::MISS_W-1:0]  miss_r,
  output logic                             defect_r,
  output logic                             chg_r
);
  logic [oam_pkg::MISS_W-1:0] miss_nxt;
  logic                       defect_nxt;

  always_comb begin
    miss_nxt = miss_r;
    if (clr) begin
      miss_nxt = '0;
    end else if (tick && miss_r != oam_pkg::MISS_LIMIT) begin
      miss_nxt = miss_r + 3'h1;
    end
    defect_nxt = defect_r;
    if (clr) begin
      defect_nxt = 1'b0;
    end else if (miss_nxt == oam_pkg::MISS_LIMIT) begin
      defect_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miss_r   <= '0;
      defect_r <= 1'b0;
      chg_r    <= 1'b0;
    end else begin
      miss_r   <= miss_nxt;
      defect_r <= defect_nxt;
      chg_r    <= defect_nxt != defect_r;
    end
  end
endmodule

// file: tb/remote_mep.sv
// remote endpoint model: sends continuity and test pdus on request
// assumes the bench calls send and sendt, one pdu per call
module remote_mep (
  input  wire logic        SYS_CLK,
  output logic             RX_CONT_VLD,
  output logic             RX_CONT_RDI,
  output logic             RX_CONT_IS_LOSS,
  output logic      [31:0] RX_CONT_SEQ,
  output logic      [5:0]  RX_SRC_PORT,
  output logic             RX_TEST_VLD,
  output logic      [31:0] RX_TEST_SEQ
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {RX_CONT_VLD, RX_CONT_RDI, RX_CONT_IS_LOSS, RX_CONT_SEQ} = '0;
  initial {RX_SRC_PORT, RX_TEST_VLD, RX_TEST_SEQ} = '0;
  // data lines show the inverse once the pdu is gone
  task send(logic [31:0] s, logic r, logic [5:0] p, logic l);
    @(posedge SYS_CLK);
    {RX_CONT_VLD, RX_CONT_SEQ, RX_CONT_RDI, RX_SRC_PORT} <= {1'h1, s, r, p};
    RX_CONT_IS_LOSS <= l;
    @(posedge SYS_CLK);
    {RX_CONT_VLD, RX_CONT_SEQ, RX_CONT_RDI, RX_SRC_PORT} <= {1'h0, ~s, ~r, ~p};
    RX_CONT_IS_LOSS <= ~l;
  endtask
  // sends one test pdu; continuity pdus are sent by send
  task sendt(logic [31:0] s);
    @(posedge SYS_CLK);
    {RX_TEST_VLD, RX_TEST_SEQ} <= {1'h1, s};
    @(posedge SYS_CLK);
    {RX_TEST_VLD, RX_TEST_SEQ} <= {1'h0, ~s};
  endtask
endmodule

// file: tb/oam_endpoint_engine_tb_top.sv
// bench for the oam endpoint engine with a remote endpoint model
// assumes the design and remote_mep are compiled first
module oam_endpoint_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK='0, SYS_RST=1'h1, RX_CONT_INVLD='0, RX_SRC_IS_LAG='0;
  logic LOSS_INSERT_TIMER_ENABLE=1'h1, INSERT_LOSS_SET='0, TX_CONT_VLD='0;
  logic RX_SEQ_CHECK_ENABLE=1'h1, EXTRACT_NEXT_CONT_SET='0, TX_TEST_VLD='0;
  logic EXTRACT_NEXT_TEST_SET='0, COPY_ALL_CONT_TO_CPU='0;
  logic COPY_ALL_CONT_LOSS_TO_CPU='0, COPY_ALL_TEST_TO_CPU='0;
  logic EXTRACT_END_TLV_ENABLE='0, TEST_PDU_HW_ENABLE=1'h1;
  logic TEST_PDU_OAM_COUNT_ENABLE=1'h1, TEST_PDU_LOSS_COUNT_ENABLE=1'h1;
  logic TEST_PDU_SEQ_WRITE_ENABLE=1'h1, RX_CONT_VLD, RX_CONT_RDI;
  logic RX_TEST_VLD, RX_CONT_IS_LOSS;
  logic [31:0] RX_CONT_SEQ, RX_TEST_SEQ;
  logic [5:0] RX_SRC_PORT, RX_LAG_MEMBER='0, LAST_SOURCE_PORT;
  logic [7:0] RX_TLV0_TYPE='0, RX_TLV0_VAL='0, RX_TLV1_TYPE='0;
  logic [7:0] RX_TLV1_VAL='0, TIMER_EXPIRE='0, PORT_STABLE_THRESHOLD=8'h03;
  logic [7:0] SAME_PORT_RUN_COUNTER, SAMPLED_IF_STATE, SAMPLED_PORT_STATE;
  logic [2:0] LOSS_TIMER_SELECT=3'h2, LOSS_INSERT_TIMER_SELECT=3'h5;
  logic [2:0] CONTINUITY_MISS_COUNTER;
  logic [10:0] FLAG_CLEAR='0, IRQ_ENABLE=11'h018, FLAGS;
  logic IRQ, LAST_REMOTE_DEFECT_VALUE, LOSS_OF_CONTINUITY_DEFECT, CPU_COPY;
  logic INSERT_LOSS_NEXT_REQUEST, TX_INSERT_LOSS, TX_TEST_SEQ_WRITE;
  logic EXTRACT_NEXT_CONT_PDU, EXTRACT_NEXT_TEST_PDU, TEST_OAM_COUNT_INC;
  logic TEST_LOSS_COUNT_INC;
  logic [31:0] STORED_RX_SEQ_VALUE, RX_OUT_OF_SEQ_COUNTER, TX_TEST_SEQ_OUT;
  logic [31:0] CONT_VALID_RX_COUNTER, CONT_INVALID_RX_COUNTER;
  logic [31:0] TX_TRANSACTION_ID_STORE, RX_TRANSACTION_ID_STORE;
  logic [31:0] TEST_VALID_RX_COUNTER, TRANSACTION_ID_ERROR_COUNTER;
  int bad_count = 0, n_tests = 0, cyc = 0;
  oam_endpoint_engine uut (.*);
  remote_mep peer (.*);
  initial forever #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (++cyc == 3000) begin
    bad_count++;
    results;
  end
  task ck(logic [63:0] g, logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task nc(int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task clr;
    @(posedge SYS_CLK) FLAG_CLEAR <= 11'h7FF;
    @(posedge SYS_CLK) FLAG_CLEAR <= '0;
  endtask
  task t_loc;
    repeat (7) @(posedge SYS_CLK) TIMER_EXPIRE <= 8'h04;
    @(posedge SYS_CLK) TIMER_EXPIRE <= '0;
    nc(1);
    ck({CONTINUITY_MISS_COUNTER, LOSS_OF_CONTINUITY_DEFECT}, 4'hF);
    nc(2);
    ck({IRQ, FLAGS[4]}, 2'h3);
    clr;
    peer.send(32'h5, 1'h0, 6'h03, 1'h0);
    nc(1);
    ck({CONTINUITY_MISS_COUNTER, LOSS_OF_CONTINUITY_DEFECT}, '0);
    ck(STORED_RX_SEQ_VALUE, 32'h5);
    nc(1);
    ck(FLAGS[4], 1'h1);
  endtask
  task t_seq;
    peer.send(32'h6, 1'h0, 6'h03, 1'h0);
    peer.send(32'h8, 1'h1, 6'h03, 1'h1);
    RX_CONT_INVLD <= 1'h1;
    @(posedge SYS_CLK) RX_CONT_INVLD <= '0;
    nc(1);
    ck(RX_OUT_OF_SEQ_COUNTER, 32'h2);
    ck({CONT_VALID_RX_COUNTER, CONT_INVALID_RX_COUNTER},
       {32'h3, 32'h1});
    ck({FLAGS[5:0], LAST_REMOTE_DEFECT_VALUE}, 7'h3F);
    ck(SAME_PORT_RUN_COUNTER, 8'h02);
  endtask
  task t_port;
    peer.send(32'h9, 1'h1, 6'h03, 1'h0);
    nc(1);
    ck(FLAGS[5], 1'h1);
    RX_SRC_IS_LAG <= 1'h1;
    RX_LAG_MEMBER <= 6'h09;
    peer.send(32'hA, 1'h1, 6'h03, 1'h0);
    nc(1);
    ck({LAST_SOURCE_PORT, SAME_PORT_RUN_COUNTER}, {6'h09, 8'h00});
  endtask
  task t_tlv;
    RX_TLV0_TYPE <= 8'h02;
    RX_TLV0_VAL  <= 8'h05;
    RX_TLV1_TYPE <= 8'h04;
    RX_TLV1_VAL  <= 8'h07;
    @(posedge SYS_CLK) EXTRACT_NEXT_CONT_SET <= 1'h1;
    @(posedge SYS_CLK) EXTRACT_NEXT_CONT_SET <= '0;
    peer.send(32'hB, 1'h1, 6'h03, 1'h0);
    nc(1);
    ck({CPU_COPY, EXTRACT_NEXT_CONT_PDU}, 2'h2);
    ck({FLAGS[7:6], SAMPLED_PORT_STATE, SAMPLED_IF_STATE},
       {2'h3, 8'h05, 8'h07});
    peer.sendt(32'h5);
    nc(1);
    ck({TEST_OAM_COUNT_INC, TEST_LOSS_COUNT_INC}, 2'h3);
    RX_TLV0_TYPE <= 8'h07;
    peer.send(32'hC, 1'h1, 6'h03, 1'h0);
    nc(1);
    ck(FLAGS[10], 1'h1);
  endtask
  task t_test;
    @(posedge SYS_CLK) TX_TEST_VLD <= 1'h1;
    @(posedge SYS_CLK);
    @(posedge SYS_CLK) TX_TEST_VLD <= '0;
    nc(1);
    ck({TX_TEST_SEQ_WRITE, TX_TEST_SEQ_OUT}, {1'h1, 32'h1});
    ck(TX_TRANSACTION_ID_STORE, 32'h2);
    peer.sendt(32'h1);
    peer.sendt(32'h4);
    nc(1);
    ck({RX_TRANSACTION_ID_STORE, FLAGS[9:8]}, {32'h4, 2'h3});
    ck({TEST_VALID_RX_COUNTER, TRANSACTION_ID_ERROR_COUNTER},
       {32'h2, 32'h1});
  endtask
  task t_ins;
    @(posedge SYS_CLK) INSERT_LOSS_SET <= 1'h1;
    @(posedge SYS_CLK) {INSERT_LOSS_SET, TX_CONT_VLD} <= 2'h1;
    @(posedge SYS_CLK) TX_CONT_VLD <= '0;
    nc(1);
    ck({TX_INSERT_LOSS, INSERT_LOSS_NEXT_REQUEST}, 2'h2);
    @(posedge SYS_CLK) TIMER_EXPIRE <= 8'h20;
    @(posedge SYS_CLK) TIMER_EXPIRE <= '0;
    nc(1);
    ck(INSERT_LOSS_NEXT_REQUEST, 1'h1);
    clr;
    nc(2);
    ck(IRQ, 1'h0);
  endtask
  task results;
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= '0;
    t_loc;
    t_seq;
    t_port;
    t_test;
    t_tlv;
    t_ins;
    results;
  end
endmodule
